//--- hdl/bccs_pkg.sv
// Package: shared constants and types for the charge-cycle sequencer
package bccs_pkg;

    // Chemistry strap decode: strap drives low / high, float is seen as neither
    typedef enum logic [1:0] {
        BCCS_ALG_CCCV = 2'h0,
        BCCS_ALG_LEAD = 2'h1,
        BCCS_ALG_CCSRC = 2'h2
    } bccs_alg_e;

    // Sequencer states, Gray coded along precondition -> cc -> cv -> done
    typedef enum logic [3:0] {
        BCCS_ST_IDLE    = 4'h0,
        BCCS_ST_PRECOND = 4'h1,
        BCCS_ST_CC      = 4'h3,
        BCCS_ST_CV      = 4'h2,
        BCCS_ST_DONE    = 4'h6,
        BCCS_ST_FLOAT   = 4'h7,
        BCCS_ST_FAULT   = 4'h5,
        BCCS_ST_SRC     = 4'h4
    } bccs_state_e;

    // Current limit levels driven to the analog loop
    typedef enum logic [1:0] {
        BCCS_ILIM_OFF     = 2'h0,
        BCCS_ILIM_FIFTEEN = 2'h1,
        BCCS_ILIM_FULL    = 2'h2
    } bccs_ilim_e;

    // Reference selections
    typedef enum logic [1:0] {
        BCCS_VREF_2V5    = 2'h0,
        BCCS_VREF_2V3125 = 2'h1,
        BCCS_VREF_NONE   = 2'h2
    } bccs_vref_e;

    // Status encoding on the two status lines {b,a}
    localparam logic [1:0] BCCS_STAT_CHARGING = 2'h3;
    localparam logic [1:0] BCCS_STAT_NOT_CHG  = 2'h2;
    localparam logic [1:0] BCCS_STAT_FAULT    = 2'h0;
    localparam logic [1:0] BCCS_STAT_FLOAT    = 2'h1;

    localparam int BCCS_SYNC_STAGES = 3;
    localparam int BCCS_NUM_FLAGS   = 9;

    // Flag positions in the synchronised comparator bundle
    localparam int BCCS_F_BELOW_PRE   = 0;
    localparam int BCCS_F_NEAR_REF    = 1;
    localparam int BCCS_F_RECHARGE    = 2;
    localparam int BCCS_F_BULK_RST    = 3;
    localparam int BCCS_F_BELOW_C10   = 4;
    localparam int BCCS_F_INSTANT_ON  = 5;
    localparam int BCCS_F_RECONNECT   = 6;
    localparam int BCCS_F_TIMER_EN    = 7;
    localparam int BCCS_F_SHUTDOWN    = 8;

    localparam logic [7:0] BCCS_BAD_BAT_RESET = 8'h00;

endpackage

//--- hdl/bccs_flag_if.sv
// Interface: synchronised comparator flags passed to the sequencer core
`timescale 1ns/100ps
`default_nettype none
interface bccs_flag_if;
    logic [bccs_pkg::BCCS_NUM_FLAGS-1:0] flag;
    modport src (output flag);
    modport dst (input flag);
endinterface
`default_nettype wire

//--- hdl/bccs_sync.sv
// Three-stage input synchroniser; a change is accepted when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module bccs_sync (
    input  wire logic                                 mclk_i,
    input  wire logic                                 nrst_i,
    input  wire logic [bccs_pkg::BCCS_NUM_FLAGS-1:0]  async_i,
    bccs_flag_if.src                                  out
);
    localparam int W = bccs_pkg::BCCS_NUM_FLAGS;

    logic [W-1:0] meta;
    logic [W-1:0] stg2;
    logic [W-1:0] stg3;
    logic [W-1:0] held;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= '0;
            stg2 <= '0;
            stg3 <= '0;
        end else begin
            meta <= async_i;
            stg2 <= meta;
            stg3 <= stg2;
        end
    end

    // Only bits where the last two stages agree may move; the first stage is never read here
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            held <= '0;
        end else begin
            held <= (stg2 & stg3) | (held & (stg2 | stg3));
        end
    end

    assign out.flag = held;
endmodule
`default_nettype wire

//--- hdl/bccs_seq.sv
// Charge-cycle sequencer top: algorithm select, stage machine, timers and status
//
// Function
// - Strap low selects constant-current/constant-voltage with trickle precondition.
// - Strap high selects the four-step three-stage lead-acid profile.
// - Strap floating selects the timed constant-current source.
// - Feedback below precondition threshold: precondition state, one-fifteenth current.
// - Above precondition: full current, constant current until near float reference.
// - Near reference: constant-voltage state; safety timer starts if timer termination.
// - Current termination: end cycle below one tenth, report not charging.
// - Timer termination: top off until end of cycle, then stop and disconnect.
// - Status line a shows not charging when current below one tenth in precondition, CC, CV and current-source states.
// - After termination, feedback at recharge threshold starts a new cycle.
// - End-of-cycle period set externally by the timing element; typical three hours.
// - Lead-acid: one-fifteenth below precondition, then full current and bulk.
// - Bulk forces full current until near reference, then absorption.
// - Absorption moves to float when current falls to one tenth.
// - Lead-acid timer starts at absorption, forces float at end of cycle.
// - Float selects lower reference, one-fifteenth current, stays indefinitely.
// - Float with feedback at bulk-restart threshold restarts bulk at full current.
// - Current-source mode: no trickle limit, full current whole timer period.
// - Current-source mode ends at end of cycle with battery switch open.
// - Current-source mode still keeps the voltage limit at the reference.
// - Current-source mode with timer grounded runs indefinitely.
// - Precondition still after one eighth of end-of-cycle flags bad battery.
// - Grounded timer pin disables every timer-based function.
// - One-tenth detection ignored in instant-on and during switch reconnection.
`timescale 1ns/100ps
`default_nettype none
module bccs_seq (
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        chem_strap_low_i,
    input  wire logic        chem_strap_high_i,
    input  wire logic        timer_term_sel_i,
    input  wire logic        fb_below_precond_i,
    input  wire logic        fb_near_ref_i,
    input  wire logic        fb_recharge_i,
    input  wire logic        fb_bulk_restart_i,
    input  wire logic        chg_below_c10_i,
    input  wire logic        instant_on_i,
    input  wire logic        path_reconnect_i,
    input  wire logic        timer_enabled_i,
    input  wire logic        shutdown_input_i,
    input  wire logic        end_of_cycle_time_i,
    input  wire logic        eighth_eoc_i,
    output logic [1:0]       ilim_level_o,
    output logic [1:0]       vref_sel_o,
    output logic             path_switch_on_o,
    output logic             timer_run_o,
    output logic             timer_clear_o,
    output logic             terminated_o,
    output logic             bad_battery_o,
    output logic             charge_status_line_a_o,
    output logic             charge_status_line_b_o,
    output logic [3:0]       state_o
);
    bccs_flag_if flags ();

    logic [bccs_pkg::BCCS_NUM_FLAGS-1:0] raw_flags;
    logic [5:0]                          ev_sync;
    logic [5:0]                          ev_s2;
    logic [5:0]                          ev_s3;
    logic [5:0]                          ev_held;

    // Event-type timer outputs from the external timing element also pass three stages
    assign raw_flags = {shutdown_input_i, timer_enabled_i, path_reconnect_i, instant_on_i,
                        chg_below_c10_i, fb_bulk_restart_i, fb_recharge_i, fb_near_ref_i,
                        fb_below_precond_i};

    bccs_sync u_sync (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .async_i (raw_flags),
        .out     (flags)
    );

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ev_sync <= 6'h00;
            ev_s2   <= 6'h00;
            ev_s3   <= 6'h00;
            ev_held <= 6'h00;
        end else begin
            // Bit 0 is a constant one; it fills with the chain and marks the straps as settled
            ev_sync <= {end_of_cycle_time_i, eighth_eoc_i, timer_term_sel_i,
                        chem_strap_high_i, chem_strap_low_i, 1'b1};
            ev_s2   <= ev_sync;
            ev_s3   <= ev_s2;
            ev_held <= (ev_s2 & ev_s3) | (ev_held & (ev_s2 | ev_s3));
        end
    end

    logic below_pre;
    logic near_ref;
    logic recharge;
    logic bulk_rst;
    logic c10_raw;
    logic c10;
    logic tmr_en;
    logic shutdown_input;
    logic eoc;
    logic eighth;

    assign below_pre = flags.flag[bccs_pkg::BCCS_F_BELOW_PRE];
    assign near_ref  = flags.flag[bccs_pkg::BCCS_F_NEAR_REF];
    assign recharge  = flags.flag[bccs_pkg::BCCS_F_RECHARGE];
    assign bulk_rst  = flags.flag[bccs_pkg::BCCS_F_BULK_RST];
    assign c10_raw   = flags.flag[bccs_pkg::BCCS_F_BELOW_C10];
    assign shutdown_input      = flags.flag[bccs_pkg::BCCS_F_SHUTDOWN];
    // Timer functions are dead when the timer pin is grounded
    assign tmr_en    = flags.flag[bccs_pkg::BCCS_F_TIMER_EN];
    assign eoc       = ev_held[5] & tmr_en;
    assign eighth    = ev_held[4] & tmr_en;
    // A premature one-tenth reading during instant-on or reconnection is masked
    assign c10       = c10_raw & ~flags.flag[bccs_pkg::BCCS_F_INSTANT_ON]
                               & ~flags.flag[bccs_pkg::BCCS_F_RECONNECT];

    // Straps are read once, after their synchroniser has filled; later changes are ignored
    bccs_pkg::bccs_alg_e alg;
    logic                alg_valid;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alg       <= bccs_pkg::BCCS_ALG_CCCV;
            alg_valid <= 1'b0;
        end else if (!alg_valid && ev_held[0]) begin
            alg_valid <= 1'b1;
            if (ev_held[1]) begin
                alg <= bccs_pkg::BCCS_ALG_CCCV;
            end else if (ev_held[2]) begin
                alg <= bccs_pkg::BCCS_ALG_LEAD;
            end else begin
                alg <= bccs_pkg::BCCS_ALG_CCSRC;
            end
        end
    end

    bccs_pkg::bccs_state_e state;
    bccs_pkg::bccs_state_e next_state;
    bccs_pkg::bccs_state_e next_go;
    logic                  timer_term;

    assign timer_term = ev_held[3] & tmr_en;

    always_comb begin
        next_state = state;
        case (state)
            bccs_pkg::BCCS_ST_IDLE: begin
                if (alg_valid) begin
                    if (alg == bccs_pkg::BCCS_ALG_CCSRC) begin
                        next_state = bccs_pkg::BCCS_ST_SRC;
                    end else if (below_pre) begin
                        next_state = bccs_pkg::BCCS_ST_PRECOND;
                    end else begin
                        next_state = bccs_pkg::BCCS_ST_CC;
                    end
                end
            end
            bccs_pkg::BCCS_ST_PRECOND: begin
                if (eighth) begin
                    next_state = bccs_pkg::BCCS_ST_FAULT;
                end else if (!below_pre) begin
                    next_state = bccs_pkg::BCCS_ST_CC;
                end
            end
            bccs_pkg::BCCS_ST_CC: begin
                if (below_pre) begin
                    next_state = bccs_pkg::BCCS_ST_PRECOND;
                end else if (near_ref) begin
                    next_state = bccs_pkg::BCCS_ST_CV;
                end
            end
            bccs_pkg::BCCS_ST_CV: begin
                if (alg == bccs_pkg::BCCS_ALG_LEAD) begin
                    if (c10 || eoc) begin
                        next_state = bccs_pkg::BCCS_ST_FLOAT;
                    end
                end else if (timer_term) begin
                    if (eoc) begin
                        next_state = bccs_pkg::BCCS_ST_DONE;
                    end
                end else if (c10) begin
                    next_state = bccs_pkg::BCCS_ST_DONE;
                end
            end
            bccs_pkg::BCCS_ST_FLOAT: begin
                if (bulk_rst) begin
                    next_state = bccs_pkg::BCCS_ST_CC;
                end
            end
            bccs_pkg::BCCS_ST_DONE: begin
                // Only the voltage algorithms recharge by themselves
                if (alg == bccs_pkg::BCCS_ALG_CCCV && recharge) begin
                    next_state = bccs_pkg::BCCS_ST_IDLE;
                end
            end
            bccs_pkg::BCCS_ST_SRC: begin
                if (eoc) begin
                    next_state = bccs_pkg::BCCS_ST_DONE;
                end
            end
            bccs_pkg::BCCS_ST_FAULT: begin
                next_state = bccs_pkg::BCCS_ST_FAULT;
            end
            default: begin
                next_state = bccs_pkg::BCCS_ST_IDLE;
            end
        endcase
    end

    // Shutdown is a synchronous restart; outputs follow it as well as the state
    assign next_go = shutdown_input ? bccs_pkg::BCCS_ST_IDLE : next_state;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= bccs_pkg::BCCS_ST_IDLE;
        end else begin
            state <= next_go;
        end
    end

    // Timer runs in precondition, from CV (absorption) entry under timer termination or lead-acid, or over the whole current-source cycle
    logic timing;
    assign timing = tmr_en && (((state == bccs_pkg::BCCS_ST_CV) &&
                                 (timer_term || alg == bccs_pkg::BCCS_ALG_LEAD)) ||
                                (state == bccs_pkg::BCCS_ST_SRC) ||
                                (state == bccs_pkg::BCCS_ST_PRECOND));

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_run_o   <= 1'b0;
            timer_clear_o <= 1'b1;
        end else begin
            timer_run_o   <= timing;
            // Held clear while idle or finished: the end-of-cycle flag lags by the
            // synchroniser, so a stale one must not reach the next cycle
            timer_clear_o <= ((next_go != state) && (next_go == bccs_pkg::BCCS_ST_CV)) ||
                             (next_go inside {bccs_pkg::BCCS_ST_IDLE, bccs_pkg::BCCS_ST_DONE,
                                              bccs_pkg::BCCS_ST_FLOAT, bccs_pkg::BCCS_ST_FAULT});
        end
    end

    // Analog steering outputs, all registered
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ilim_level_o     <= bccs_pkg::BCCS_ILIM_OFF;
            vref_sel_o       <= bccs_pkg::BCCS_VREF_2V5;
            path_switch_on_o <= 1'b0;
        end else begin
            case (next_go)
                bccs_pkg::BCCS_ST_PRECOND: begin
                    ilim_level_o     <= bccs_pkg::BCCS_ILIM_FIFTEEN;
                    vref_sel_o       <= bccs_pkg::BCCS_VREF_2V5;
                    path_switch_on_o <= 1'b1;
                end
                bccs_pkg::BCCS_ST_CC, bccs_pkg::BCCS_ST_CV: begin
                    ilim_level_o     <= bccs_pkg::BCCS_ILIM_FULL;
                    vref_sel_o       <= bccs_pkg::BCCS_VREF_2V5;
                    path_switch_on_o <= 1'b1;
                end
                bccs_pkg::BCCS_ST_FLOAT: begin
                    ilim_level_o     <= bccs_pkg::BCCS_ILIM_FIFTEEN;
                    vref_sel_o       <= bccs_pkg::BCCS_VREF_2V3125;
                    path_switch_on_o <= 1'b1;
                end
                bccs_pkg::BCCS_ST_SRC: begin
                    ilim_level_o     <= bccs_pkg::BCCS_ILIM_FULL;
                    vref_sel_o       <= bccs_pkg::BCCS_VREF_2V5;
                    path_switch_on_o <= 1'b1;
                end
                default: begin
                    // Done, fault and idle: no current, battery path high impedance
                    ilim_level_o     <= bccs_pkg::BCCS_ILIM_OFF;
                    vref_sel_o       <= bccs_pkg::BCCS_VREF_2V5;
                    path_switch_on_o <= 1'b0;
                end
            endcase
        end
    end

    // Status lines; line a follows the one-tenth level in precondition, CC, CV and current-source states
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            terminated_o           <= 1'b0;
            bad_battery_o          <= 1'b0;
            charge_status_line_a_o <= 1'b0;
            charge_status_line_b_o <= 1'b0;
        end else begin
            terminated_o  <= (next_go == bccs_pkg::BCCS_ST_DONE);
            bad_battery_o <= (next_go == bccs_pkg::BCCS_ST_FAULT);
            case (next_go)
                bccs_pkg::BCCS_ST_FAULT: begin
                    {charge_status_line_b_o, charge_status_line_a_o} <= bccs_pkg::BCCS_STAT_FAULT;
                end
                bccs_pkg::BCCS_ST_DONE, bccs_pkg::BCCS_ST_IDLE: begin
                    {charge_status_line_b_o, charge_status_line_a_o} <= bccs_pkg::BCCS_STAT_NOT_CHG;
                end
                bccs_pkg::BCCS_ST_FLOAT: begin
                    {charge_status_line_b_o, charge_status_line_a_o} <= bccs_pkg::BCCS_STAT_FLOAT;
                end
                default: begin
                    charge_status_line_b_o <= 1'b1;
                    charge_status_line_a_o <= ~c10;
                end
            endcase
        end
    end

    assign state_o = state;

    // Checks
    property p_fault_sticks;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == bccs_pkg::BCCS_ST_FAULT && !shutdown_input) |=> (state == bccs_pkg::BCCS_ST_FAULT);
    endproperty
    a_fault_sticks: assert property (p_fault_sticks) else $error("fault left");

    property p_precond_limit;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == bccs_pkg::BCCS_ST_PRECOND) |-> (ilim_level_o == bccs_pkg::BCCS_ILIM_FIFTEEN);
    endproperty
    a_precond_limit: assert property (p_precond_limit) else $error("precond limit");

    property p_float_ref;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == bccs_pkg::BCCS_ST_FLOAT) |-> (vref_sel_o == bccs_pkg::BCCS_VREF_2V3125 &&
                                                 ilim_level_o == bccs_pkg::BCCS_ILIM_FIFTEEN);
    endproperty
    a_float_ref: assert property (p_float_ref) else $error("float ref");

    property p_done_open;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == bccs_pkg::BCCS_ST_DONE) |-> !path_switch_on_o && ilim_level_o == 2'h0;
    endproperty
    a_done_open: assert property (p_done_open) else $error("path not open");

    property p_src_no_restart;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == bccs_pkg::BCCS_ST_DONE && alg == bccs_pkg::BCCS_ALG_CCSRC && !shutdown_input)
            |=> (state == bccs_pkg::BCCS_ST_DONE);
    endproperty
    a_src_no_restart: assert property (p_src_no_restart) else $error("src restart");

    property p_no_timer_no_eoc;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == bccs_pkg::BCCS_ST_SRC && !tmr_en && !shutdown_input) |=> (state == bccs_pkg::BCCS_ST_SRC);
    endproperty
    a_no_timer_no_eoc: assert property (p_no_timer_no_eoc) else $error("src ended");

    property p_bulk_restart;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == bccs_pkg::BCCS_ST_FLOAT && bulk_rst && !shutdown_input)
            |=> (state == bccs_pkg::BCCS_ST_CC && ilim_level_o == bccs_pkg::BCCS_ILIM_FULL);
    endproperty
    a_bulk_restart: assert property (p_bulk_restart) else $error("bulk restart");

    property p_c10_masked;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == bccs_pkg::BCCS_ST_CV && flags.flag[bccs_pkg::BCCS_F_INSTANT_ON] && !eoc && !shutdown_input)
            |=> (state == bccs_pkg::BCCS_ST_CV);
    endproperty
    a_c10_masked: assert property (p_c10_masked) else $error("c10 not masked");
endmodule
`default_nettype wire

//--- verification/bccs_batt_model.sv
// Battery model: comparator flags and end-of-cycle timer seen by the sequencer
`timescale 1ns/100ps
`default_nettype none
module bccs_batt_model #(
    parameter int EOC_CYCLES = 64
) (
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic [15:0] fb_mv_i,
    input  wire logic [7:0]  cur_pct_i,
    input  wire logic        timer_en_i,
    input  wire logic        timer_run_i,
    input  wire logic        timer_clear_i,
    output logic [4:0]       flags_o,
    output logic             eighth_o,
    output logic             eoc_o
);
    int cnt;
    // Flags: below precondition, near reference, recharge, bulk restart, below one tenth
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_o <= 5'h00;
        end else begin
            flags_o <= {cur_pct_i < 8'h0a, fb_mv_i <= 16'h088b, fb_mv_i <= 16'h0985,
                        fb_mv_i >= 16'h09ba, fb_mv_i < 16'h06d6};
        end
    end
    // A grounded timing pin never counts, so no timed event is ever seen
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 0;
        end else if (timer_clear_i || !timer_en_i) begin
            cnt <= 0;
        end else if (timer_run_i && cnt < EOC_CYCLES) begin
            cnt <= cnt + 1;
        end
    end
    assign eighth_o = cnt >= EOC_CYCLES / 8;
    assign eoc_o    = cnt >= EOC_CYCLES;
endmodule
`default_nettype wire

//--- verification/battery_charge_cycle_sequencer_bench.sv
// Self-checking bench for the charge-cycle sequencer
`timescale 1ns/100ps
`default_nettype none
module battery_charge_cycle_sequencer_bench;
    logic mclk_i = 1'b0, nrst_i = 1'b0, sl = 1'b0, sh = 1'b0, ts = 1'b0, ion = 1'b0;
    logic recon = 1'b0, ten = 1'b0, shutdown_input = 1'b0, run, clr, eighth, eoc, term, bad, sa, sb;
    logic [15:0] fb = 16'h0000;
    logic [7:0]  cur = 8'h32;
    logic [4:0]  fl;
    logic [1:0]  ilim, vref;
    logic [3:0]  st, last_st = 4'h0;
    logic        path;
    logic [5:0]  q[$];
    logic [5:0]  note;
    logic [31:0] seed = 32'hbff8;
    int err_total = 0, num_checks = 0;
    always #5 mclk_i = ~mclk_i;
    bccs_batt_model #(.EOC_CYCLES(64)) batt (.mclk_i(mclk_i), .nrst_i(nrst_i), .fb_mv_i(fb),
        .cur_pct_i(cur), .timer_en_i(ten), .timer_run_i(run), .timer_clear_i(clr),
        .flags_o(fl), .eighth_o(eighth), .eoc_o(eoc));
    bccs_seq DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .chem_strap_low_i(sl),
        .chem_strap_high_i(sh), .timer_term_sel_i(ts), .fb_below_precond_i(fl[0]),
        .fb_near_ref_i(fl[1]), .fb_recharge_i(fl[2]), .fb_bulk_restart_i(fl[3]),
        .chg_below_c10_i(fl[4]), .instant_on_i(ion), .path_reconnect_i(recon),
        .timer_enabled_i(ten), .shutdown_input_i(shutdown_input), .end_of_cycle_time_i(eoc),
        .eighth_eoc_i(eighth), .ilim_level_o(ilim), .vref_sel_o(vref),
        .path_switch_on_o(path), .timer_run_o(run), .timer_clear_o(clr),
        .terminated_o(term), .bad_battery_o(bad), .charge_status_line_a_o(sa),
        .charge_status_line_b_o(sb), .state_o(st));
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic expect_st(input bccs_pkg::bccs_state_e s, input bccs_pkg::bccs_ilim_e l);
        q.push_back({s, l});
    endtask
    function automatic logic [15:0] cc_mv();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return 16'(1800 + seed % 600);
    endfunction
    task automatic start(input logic l, h, t, e, input logic [15:0] v);
        @(posedge mclk_i);
        nrst_i <= 1'b0;
        {sl, sh, ts, ten, fb, cur} <= {l, h, t, e, v, 8'h32};
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'b1;
    endtask
    task automatic drive(input logic [15:0] v, input logic [7:0] c);
        @(posedge mclk_i);
        fb  <= v;
        cur <= c;
    endtask
    task automatic settle(input string name);
        int n;
        n = 0;
        while (q.size() != 0 && n < 300) begin
            @(posedge mclk_i);
            n++;
        end
        if (q.size() != 0) check("pending_state", 8'h00, 8'hff);
        q.delete();
        repeat (2) @(posedge mclk_i);
        $display("TEST %s done", name);
    endtask
    // Every state change must have been announced by the driving process
    always @(negedge mclk_i) begin
        if (!nrst_i) begin
            last_st = 4'h0;
        end else if (st !== last_st) begin
            last_st = st;
            if (q.size() == 0) begin
                check("unexpected_state", {4'h0, st}, 8'hff);
            end else begin
                note = q.pop_front();
                check("state", {4'h0, st}, {4'h0, note[5:2]});
                check("ilim", {6'h0, ilim}, {6'h0, note[1:0]});
            end
        end
    end
    initial begin
        #200000;
        check("watchdog", 8'h00, 8'hff);
        finish_test();
    end
    initial begin
        expect_st(bccs_pkg::BCCS_ST_CC, bccs_pkg::BCCS_ILIM_FULL);
        start(1, 0, 0, 1, cc_mv());
        expect_st(bccs_pkg::BCCS_ST_CV, bccs_pkg::BCCS_ILIM_FULL);
        drive(16'h09c4, 8'h32);
        settle("cccv_cv");
        check("path", {7'h0, path}, 8'h01);
        @(posedge mclk_i);
        ion <= 1'b1;
        drive(16'h09c4, 8'h05);
        repeat (20) @(posedge mclk_i);
        ion   <= 1'b0;
        recon <= 1'b1;
        repeat (20) @(posedge mclk_i);
        expect_st(bccs_pkg::BCCS_ST_DONE, bccs_pkg::BCCS_ILIM_OFF);
        recon <= 1'b0;
        settle("cccv_c10");
        check("status", {6'h0, sb, sa}, {6'h0, bccs_pkg::BCCS_STAT_NOT_CHG});
        check("path", {7'h0, path}, 8'h00);
        check("term", {7'h0, term}, 8'h01);
        expect_st(bccs_pkg::BCCS_ST_IDLE, bccs_pkg::BCCS_ILIM_OFF);
        expect_st(bccs_pkg::BCCS_ST_CC, bccs_pkg::BCCS_ILIM_FULL);
        drive(16'h0960, 8'h32);
        settle("cccv_recharge");
        expect_st(bccs_pkg::BCCS_ST_CC, bccs_pkg::BCCS_ILIM_FULL);
        start(1, 0, 1, 1, cc_mv());
        expect_st(bccs_pkg::BCCS_ST_CV, bccs_pkg::BCCS_ILIM_FULL);
        drive(16'h09c4, 8'h32);
        settle("timer_cv");
        drive(16'h09c4, 8'h05);
        repeat (8) @(posedge mclk_i);
        check("status_a", {7'h0, sa}, 8'h00);
        check("state", {4'h0, st}, {4'h0, bccs_pkg::BCCS_ST_CV});
        expect_st(bccs_pkg::BCCS_ST_DONE, bccs_pkg::BCCS_ILIM_OFF);
        settle("timer_eoc");
        check("path", {7'h0, path}, 8'h00);
        expect_st(bccs_pkg::BCCS_ST_PRECOND, bccs_pkg::BCCS_ILIM_FIFTEEN);
        expect_st(bccs_pkg::BCCS_ST_FAULT, bccs_pkg::BCCS_ILIM_OFF);
        start(1, 0, 0, 1, 16'h05dc);
        settle("bad_battery");
        check("bad", {6'h0, sb, bad}, 8'h01);
        expect_st(bccs_pkg::BCCS_ST_PRECOND, bccs_pkg::BCCS_ILIM_FIFTEEN);
        start(0, 1, 0, 0, 16'h05dc);
        settle("lead_pre");
        expect_st(bccs_pkg::BCCS_ST_CC, bccs_pkg::BCCS_ILIM_FULL);
        drive(cc_mv(), 8'h32);
        settle("lead_bulk");
        expect_st(bccs_pkg::BCCS_ST_CV, bccs_pkg::BCCS_ILIM_FULL);
        drive(16'h09c4, 8'h32);
        settle("lead_abs");
        expect_st(bccs_pkg::BCCS_ST_FLOAT, bccs_pkg::BCCS_ILIM_FIFTEEN);
        drive(16'h09c4, 8'h05);
        settle("lead_float");
        check("vref", {6'h0, vref}, 8'h01);
        expect_st(bccs_pkg::BCCS_ST_CC, bccs_pkg::BCCS_ILIM_FULL);
        drive(16'h0866, 8'h32);
        settle("lead_restart");
        check("vref", {6'h0, vref}, 8'h00);
        expect_st(bccs_pkg::BCCS_ST_CC, bccs_pkg::BCCS_ILIM_FULL);
        start(0, 1, 0, 1, cc_mv());
        expect_st(bccs_pkg::BCCS_ST_CV, bccs_pkg::BCCS_ILIM_FULL);
        drive(16'h09c4, 8'h32);
        expect_st(bccs_pkg::BCCS_ST_FLOAT, bccs_pkg::BCCS_ILIM_FIFTEEN);
        settle("lead_timer");
        expect_st(bccs_pkg::BCCS_ST_SRC, bccs_pkg::BCCS_ILIM_FULL);
        start(0, 0, 0, 1, 16'h05dc);
        repeat (12) @(posedge mclk_i);
        check("vref", {6'h0, vref}, 8'h00);
        expect_st(bccs_pkg::BCCS_ST_DONE, bccs_pkg::BCCS_ILIM_OFF);
        settle("src_eoc");
        check("path", {7'h0, path}, 8'h00);
        drive(16'h07d0, 8'h32);
        repeat (20) @(posedge mclk_i);
        expect_st(bccs_pkg::BCCS_ST_IDLE, bccs_pkg::BCCS_ILIM_OFF);
        expect_st(bccs_pkg::BCCS_ST_SRC, bccs_pkg::BCCS_ILIM_FULL);
        shutdown_input <= 1'b1;
        repeat (8) @(posedge mclk_i);
        shutdown_input <= 1'b0;
        settle("src_shutdown");
        expect_st(bccs_pkg::BCCS_ST_SRC, bccs_pkg::BCCS_ILIM_FULL);
        start(0, 0, 0, 0, 16'h05dc);
        repeat (150) @(posedge mclk_i);
        check("state", {4'h0, st}, {4'h0, bccs_pkg::BCCS_ST_SRC});
        settle("src_no_timer");
        finish_test();
    end
endmodule
`default_nettype wire
